// ===== pwb_pkg.sv
// pwb_pkg: constants, layouts and types for the pulse width timer and tone block
package pwb_pkg;

  // ***********************************************
  // register map (byte addresses, one word each)
  // ***********************************************
  localparam logic [4:0] PWB_ADDR_CTRL8 = 5'h00;
  localparam logic [4:0] PWB_ADDR_CTRL16 = 5'h04;
  localparam logic [4:0] PWB_ADDR_CNT8 = 5'h08;
  localparam logic [4:0] PWB_ADDR_CNT16 = 5'h0C;
  localparam logic [4:0] PWB_ADDR_INTC = 5'h10;
  localparam logic [4:0] PWB_ADDR_PORTB = 5'h14;
  localparam logic [4:0] PWB_ADDR_PORTB_DIR = 5'h18;

  // ***********************************************
  // field positions and reset values
  // ***********************************************
  localparam int PWB_INTC_EN_LSB = 0;     // bits 1:0 enables, timer8 then timer16
  localparam int PWB_INTC_FLAG_LSB = 2;   // bits 3:2 request flags
  localparam int PWB_PB_GATE = 0;         // tone_gate_data_bit
  localparam int PWB_PB_SECOND = 1;       // tone_second_data_bit
  localparam int PWB_PB_PIN_LSB = 2;      // bits 3:2 pin levels, read only
  localparam logic [1:0] PWB_DIR_RESET = 2'h3;   // 1 = input
  localparam logic [15:0] PWB_TOP8 = 16'h00FF;
  localparam logic [15:0] PWB_TOP16 = 16'hFFFF;
  localparam logic [15:0] PWB_CNT_RESET = 16'h0000;

  // ***********************************************
  // timing: 20 MHz system clock, timer16 runs at clock / 4
  // ***********************************************
  localparam int PWB_SYS_CLK_HZ = 20_000_000;
  localparam logic [1:0] PWB_DIV4_LAST = 2'h3;
  localparam logic [1:0] PWB_RESP_OKAY = 2'h0;
  localparam logic [1:0] PWB_RESP_SLVERR = 2'h2;

  // ***********************************************
  // types
  // ***********************************************
  typedef enum logic [1:0] {
    PWB_MODE_OFF = 2'b00,
    PWB_MODE_EVENT = 2'b01,
    PWB_MODE_TIMER = 2'b10,
    PWB_MODE_PULSE = 2'b11
  } pwb_mode_t;

  // control register layout: mode 7:6, spare 5, run 4, edge 3, prescale 2:0
  typedef struct packed {
    pwb_mode_t mode;
    logic spare;
    logic run;
    logic edge_sel;
    logic [2:0] psc;
  } pwb_ctrl_t;

  typedef enum logic [2:0] {
    PWB_PW_WAIT = 3'b001,
    PWB_PW_COUNT = 3'b010,
    PWB_PW_DONE = 3'b100
  } pwb_pw_state_t;

endpackage

// ===== pwb_timer.sv
// pwb_timer: 8/16-bit timer counters with pulse width mode, tone divider and AXI4-Lite slave
// Operation
// [R01] pulse width: 8-bit counter runs on prescaled clock, 16-bit on clock / 4.
// [R02] three-bit prescale_rate_sel in control bits 2:0 sets prescaler ratio.
// [R03] with run set in pulse width mode, counter idles until active edge.
// [R04] active_edge_sel low: count from falling edge until pin high, clear run.
// [R05] active_edge_sel high: count from rising edge until pin low, clear run.
// [R06] run clears itself only in pulse width mode; otherwise only software clears.
// [R07] after self clear, pin transitions ignored until software sets run again.
// [R08] counter keeps its residual count as the measured pulse length.
// [R09] overflow raises interrupt, reloads from preload, keeps counting.
// [R10] timer interrupt suppressed when its enable bit is zero.
// [R11] software selects pin mode and sets pin direction to input.
// [R12] tone toggle source is 8-bit or 16-bit overflow, fixed option.
// [R13] each selected overflow inverts tone_out and its complement together.
// [R14] tones toggle only while gate bit is 1; otherwise both outputs low.
// [R15] second port data bit has no effect on tone outputs.
// [R16] tone pin drives only when its direction bit says output.
// [R17] counter clock inhibited during counter read or preload write.
// [R18] pin edges and levels recognised only at the next timer clock pulse.
// [R19] every overflow sets request flag and wakes from power-down regardless; here a flag already set masks the wake.
// [R20] software sets request flag before power-down to prevent overflow wake.
// [R21] software sets run only after mode bits are configured.
// [R22] software loads an initial count before enabling the timer.
// [R23] mode bits 7:6: 10 timer, 01 event counter.
// [R24] during the active pulse the counter increments on each timer clock.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
module pwb_timer
  import pwb_pkg::*;
#(
  parameter bit TONE_SRC_16 = 1'b0,  // toggle source: 0 = 8-bit overflow
  parameter bit TONE_ENABLE = 1'b1   // tone function on port b pins
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // axi4-lite write address and data
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // external timer inputs
  input wire logic ext_timer_input,
  input wire logic ext_timer_input_16,
  // tone pins, shared with port b bits 0 and 1
  output logic tone_out,
  output logic tone_out_oe,
  input wire logic tone_out_in,
  output logic tone_out_n,
  output logic tone_out_n_oe,
  input wire logic tone_out_n_in,
  // core side: interrupt requests, power-down state, wake-up
  output logic [1:0] timer_irq,
  input wire logic sleep_mode,
  output logic wake_up
);

  // ***********************************************
  // helper functions
  // ***********************************************
  // byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? wd[15:8] : old_v[15:8], strb[0] ? wd[7:0] : old_v[7:0]};
  endfunction

  // prescaler mask: ratio is 2 to the power (sel + 1)
  function automatic logic [7:0] psc_mask(input logic [2:0] sel);
    psc_mask = 8'hFF >> (3'h7 - sel);
  endfunction

  // ***********************************************
  // bus slave state
  // ***********************************************
  logic aw_full_reg, w_full_reg;
  logic [4:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic [31:0] rd_mux;
  logic rd_ok, wr_ok;
  logic ar_hs;
  logic [1:0] wr_ctrl, wr_pre, rd_cnt, inhibit;
  logic wr_intc, wr_portb, wr_dir;

  assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  // write address and data are taken in any order, then executed together
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PWB_RESP_OKAY;
      awaddr_reg <= 5'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      s_axi_awready <= !aw_full_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_full_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_awready <= 1'b0;  // reopened after the response
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? PWB_RESP_OKAY : PWB_RESP_SLVERR;
      end
      else if (s_axi_bvalid)
      begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        if (s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write decode, one strobe per register
  always_comb
  begin
    wr_ctrl = {wr_fire && awaddr_reg == PWB_ADDR_CTRL16, wr_fire && awaddr_reg == PWB_ADDR_CTRL8};
    wr_pre = {wr_fire && awaddr_reg == PWB_ADDR_CNT16, wr_fire && awaddr_reg == PWB_ADDR_CNT8};
    wr_intc = wr_fire && awaddr_reg == PWB_ADDR_INTC;
    wr_portb = wr_fire && awaddr_reg == PWB_ADDR_PORTB;
    wr_dir = wr_fire && awaddr_reg == PWB_ADDR_PORTB_DIR;
    wr_ok = (|wr_ctrl) || (|wr_pre) || wr_intc || wr_portb || wr_dir;
    rd_cnt = {ar_hs && s_axi_araddr == PWB_ADDR_CNT16, ar_hs && s_axi_araddr == PWB_ADDR_CNT8};
    inhibit = rd_cnt | wr_pre;  // [R17]
  end

  // ***********************************************
  // timer, interrupt and port state
  // ***********************************************
  pwb_ctrl_t ctrl_reg [2];
  logic [15:0] cnt_reg [2];
  logic [15:0] pre_reg [2];
  logic [1:0] flag_reg, ovf, int_en_reg;
  logic [1:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
  logic [1:0] pb_data_reg, pb_dir_reg, pbin_meta_reg, pbin_sync_reg;
  logic [7:0] psc_cnt_reg;
  logic [1:0] div_cnt_reg;
  logic psc_tick, div4_tick;
  logic tone_state_reg;

  // read mux: control, counter, interrupt, port registers
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      PWB_ADDR_CTRL8: rd_mux[7:0] = ctrl_reg[0];
      PWB_ADDR_CTRL16: rd_mux[7:0] = ctrl_reg[1];
      PWB_ADDR_CNT8: rd_mux[15:0] = cnt_reg[0];
      PWB_ADDR_CNT16: rd_mux[15:0] = cnt_reg[1];
      PWB_ADDR_INTC: rd_mux[3:0] = {flag_reg, int_en_reg};
      PWB_ADDR_PORTB: rd_mux[3:0] = {pbin_sync_reg, pb_data_reg};
      PWB_ADDR_PORTB_DIR: rd_mux[1:0] = pb_dir_reg;
      default: rd_ok = 1'b0;
    endcase
  end

  // read channel: one read in flight, answered the cycle after address
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PWB_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? PWB_RESP_OKAY : PWB_RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= 1'b1;
  end

  // pin synchronisers; async pins are only seen two flops later
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
      pin_prev_reg <= 2'h0;
      pbin_meta_reg <= 2'h0;
      pbin_sync_reg <= 2'h0;
    end
    else
    begin
      pin_meta_reg <= {ext_timer_input_16, ext_timer_input};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
      pbin_meta_reg <= {tone_out_n_in, tone_out_in};
      pbin_sync_reg <= pbin_meta_reg;
    end
  end

  // clock enables: free prescaler for timer8, clock / 4 for timer16
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      psc_cnt_reg <= 8'h00;
      div_cnt_reg <= 2'h0;
    end
    else
    begin
      psc_cnt_reg <= psc_cnt_reg + 8'h01;
      div_cnt_reg <= div_cnt_reg + 2'h1;
    end
  end
  assign psc_tick = (psc_cnt_reg & psc_mask(ctrl_reg[0].psc)) == psc_mask(ctrl_reg[0].psc);  // [R02]
  assign div4_tick = div_cnt_reg == PWB_DIV4_LAST;

  // ***********************************************
  // the two timers
  // ***********************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  for (genvar i = 0; i < 2; i++)
  begin : gen_tmr
    localparam logic [15:0] TOP = (i == 0) ? PWB_TOP8 : PWB_TOP16;
    logic clk_tick, tk, evt_tick, act_lvl, pin, pw_mode, pw_start, pw_end, cnt_en;
    logic lvl_tick_reg;
    pwb_pw_state_t pw_reg;

    always_comb
    begin
      clk_tick = (i == 0) ? psc_tick : div4_tick;  // [R01]
      tk = clk_tick && !inhibit[i];  // [R17]
      pin = pin_sync_reg[i];
      act_lvl = ctrl_reg[i].edge_sel;  // [R04] [R05]
      // event mode: edge_sel low counts rising edges, high counts falling edges
      evt_tick = !inhibit[i] && (ctrl_reg[i].edge_sel ? (pin_prev_reg[i] && !pin) : (!pin_prev_reg[i] && pin));
      pw_mode = ctrl_reg[i].mode == PWB_MODE_PULSE;
      // edges are judged on the level sampled at timer clock pulses
      pw_start = pw_reg == PWB_PW_WAIT && lvl_tick_reg != act_lvl && pin == act_lvl;  // [R18] [R03]
      pw_end = pw_mode && ctrl_reg[i].run && tk && pw_reg == PWB_PW_COUNT && pin != act_lvl;
      case (ctrl_reg[i].mode)  // [R23]
        PWB_MODE_TIMER: cnt_en = ctrl_reg[i].run && tk;
        PWB_MODE_EVENT: cnt_en = ctrl_reg[i].run && evt_tick;
        PWB_MODE_PULSE: cnt_en = ctrl_reg[i].run && tk && (pw_start || (pw_reg == PWB_PW_COUNT && pin == act_lvl));  // [R24]
        default: cnt_en = 1'b0;
      endcase
      ovf[i] = cnt_en && cnt_reg[i] == TOP;
    end

    // level at the last timer clock pulse, for edge detection in pulse mode
    always_ff @(posedge sys_clk)
    begin
      if (!resetn)
        lvl_tick_reg <= 1'b0;
      else if (tk)
        lvl_tick_reg <= pin;  // [R18]
    end

    // pulse measurement sequence; DONE holds until software rearms
    always_ff @(posedge sys_clk)
    begin
      if (!resetn)
        pw_reg <= PWB_PW_WAIT;
      else if (!pw_mode || !ctrl_reg[i].run)
        pw_reg <= (pw_reg == PWB_PW_DONE && pw_mode && !wr_ctrl[i]) ? PWB_PW_DONE : PWB_PW_WAIT;  // [R07]
      else if (tk)
      begin
        case (pw_reg)
          PWB_PW_WAIT: pw_reg <= pw_start ? PWB_PW_COUNT : PWB_PW_WAIT;  // [R03]
          PWB_PW_COUNT: pw_reg <= pw_end ? PWB_PW_DONE : PWB_PW_COUNT;
          PWB_PW_DONE: pw_reg <= PWB_PW_DONE;
          default: pw_reg <= PWB_PW_WAIT;
        endcase
      end
    end

    // control register; run clears itself only at the end of a pulse
    always_ff @(posedge sys_clk)
    begin
      if (!resetn)
        ctrl_reg[i] <= '0;
      else if (wr_ctrl[i] && wstrb_reg[0])
        ctrl_reg[i] <= (i == 0) ? pwb_ctrl_t'(wdata_reg[7:0]) : pwb_ctrl_t'({wdata_reg[7:3], 3'h0});
      else if (pw_end)
        ctrl_reg[i].run <= 1'b0;  // [R04] [R05] [R06]
    end

    // preload, and the counter with reload on overflow; residue kept after stop
    always_ff @(posedge sys_clk)
    begin
      if (!resetn)
      begin
        pre_reg[i] <= PWB_CNT_RESET;
        cnt_reg[i] <= PWB_CNT_RESET;
      end
      else if (wr_pre[i])
      begin
        pre_reg[i] <= merge16(pre_reg[i], wdata_reg, wstrb_reg) & TOP;
        if (!ctrl_reg[i].run)
          cnt_reg[i] <= merge16(pre_reg[i], wdata_reg, wstrb_reg) & TOP;  // loads a stopped counter
      end
      else if (ovf[i])
        cnt_reg[i] <= pre_reg[i];  // [R09]
      else if (cnt_en)
        cnt_reg[i] <= cnt_reg[i] + 16'h0001;  // [R24] [R08]
    end

    // request flag: overflow wins over a software clear in the same cycle
    always_ff @(posedge sys_clk)
    begin
      if (!resetn)
        flag_reg[i] <= 1'b0;
      else
        flag_reg[i] <= (wr_intc ? wdata_reg[PWB_INTC_FLAG_LSB + i] : flag_reg[i]) | ovf[i];  // [R19]
    end

    // interrupt line gated by its enable
    always_ff @(posedge sys_clk)
    begin
      if (!resetn)
        timer_irq[i] <= 1'b0;
      else
        timer_irq[i] <= int_en_reg[i] && (flag_reg[i] || ovf[i]);  // [R09] [R10]
    end

    sequence s_pulse_end;
      pw_mode && ctrl_reg[i].run && pw_reg == PWB_PW_COUNT && tk && pin != act_lvl && !wr_ctrl[i];
    endsequence
    sequence s_run_dropped;
      !ctrl_reg[i].run ##1 pw_reg == PWB_PW_DONE;
    endsequence

    a_pw_self_clear: assert property (s_pulse_end |=> s_run_dropped)  // [R04] [R05]
      else $error("run bit not cleared at end of pulse");
    a_run_sw_only: assert property ($fell(ctrl_reg[i].run) && !$past(wr_ctrl[i]) |-> $past(pw_mode))  // [R06]
      else $error("run bit cleared outside pulse mode");
    a_single_shot: assert property (pw_reg == PWB_PW_DONE && !wr_pre[i] |=> $stable(cnt_reg[i]))  // [R07] [R08]
      else $error("counter moved after measurement");
    a_pw_idle: assert property (pw_mode && pw_reg == PWB_PW_WAIT && !(tk && pin == act_lvl) && !wr_pre[i]
                                |=> $stable(cnt_reg[i]))  // [R03]
      else $error("counter moved before active edge");
    a_ovf_reload: assert property (ovf[i] |=> cnt_reg[i] == $past(pre_reg[i]) && flag_reg[i])  // [R09]
      else $error("no reload or flag after overflow");
    a_irq_masked: assert property (!int_en_reg[i] |=> !timer_irq[i])  // [R10]
      else $error("interrupt raised while disabled");
    a_read_inhibit: assert property (rd_cnt[i] |=> $stable(cnt_reg[i]))  // [R17]
      else $error("counter advanced during read");
  end

  // ***********************************************
  // interrupt enables, port b data and direction
  // ***********************************************
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      int_en_reg <= 2'h0;
      pb_data_reg <= 2'h0;
      pb_dir_reg <= PWB_DIR_RESET;
    end
    else
    begin
      if (wr_intc && wstrb_reg[0])
        int_en_reg <= wdata_reg[PWB_INTC_EN_LSB +: 2];
      if (wr_portb && wstrb_reg[0])
        pb_data_reg <= wdata_reg[1:0];
      if (wr_dir && wstrb_reg[0])
        pb_dir_reg <= wdata_reg[1:0];
    end
  end

  // wake-up pulse: a flag already set by software masks the wake
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      wake_up <= 1'b0;
    else
      wake_up <= sleep_mode && |(ovf & ~flag_reg);  // [R19]
  end

  // ***********************************************
  // tone divider and pins
  // ***********************************************
  logic tone_ovf, gate;
  assign tone_ovf = TONE_SRC_16 ? ovf[1] : ovf[0];  // [R12]
  assign gate = pb_data_reg[PWB_PB_GATE];  // [R15] second data bit not used here

  // toggle state; forced low while the gate bit is clear
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      tone_state_reg <= 1'b0;
    else if (!gate)
      tone_state_reg <= 1'b0;  // [R14]
    else if (tone_ovf)
      tone_state_reg <= !tone_state_reg;  // [R13]
  end

  // pin drivers; without the tone option the pins are plain port outputs
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      tone_out <= 1'b0;
      tone_out_n <= 1'b0;
      tone_out_oe <= 1'b0;
      tone_out_n_oe <= 1'b0;
    end
    else
    begin
      tone_out <= TONE_ENABLE ? (gate && (tone_state_reg ^ tone_ovf)) : gate;  // [R13] [R14]
      tone_out_n <= TONE_ENABLE ? (gate && !(tone_state_reg ^ tone_ovf)) : pb_data_reg[PWB_PB_SECOND];
      tone_out_oe <= !pb_dir_reg[0];  // [R16]
      tone_out_n_oe <= !pb_dir_reg[1];  // [R16]
    end
  end

  a_tone_low_gated: assert property (!gate |=> !tone_out && !tone_out_n)  // [R14]
    else $error("tone outputs not low with gate clear");
  a_tone_compl: assert property (gate && $past(gate) && TONE_ENABLE |-> tone_out != tone_out_n)  // [R13]
    else $error("tone outputs not complementary");
  a_tone_toggle: assert property (gate && tone_ovf && TONE_ENABLE |=> $changed(tone_out))  // [R13]
    else $error("tone did not toggle on overflow");
  a_pin_drive: assert property (pb_dir_reg[0] |=> !tone_out_oe)  // [R16]
    else $error("tone pin driven while input");

endmodule  // pwb_timer

// ===== pwb_pulse_src.sv
// pwb_pulse_src: pulse source for the timer pin and piezo load on the tone pins
module pwb_pulse_src
(
  // clock and pulse request
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [7:0] len,
  input wire logic act_lvl,
  // timer pin
  output logic ext_pin,
  // tone pins as the load sees them
  input wire logic tone_out,
  input wire logic tone_out_oe,
  input wire logic tone_out_n,
  input wire logic tone_out_n_oe,
  output logic tone_pin,
  output logic tone_n_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_reg = 8'h00;
  logic last_reg = 1'b0;
  logic last_n_reg = 1'b0;
  // one shot of len cycles at the active level, idle otherwise
  always_ff @(posedge sys_clk)
  begin
    if (go)
      left_reg <= len;
    else if (left_reg != 8'h00)
      left_reg <= left_reg - 8'h01;
  end
  assign ext_pin = (left_reg != 8'h00) ? act_lvl : ~act_lvl;
  // piezo has no pull: an undriven pin wanders, never holds its last value
  always_ff @(posedge sys_clk)
  begin
    last_reg <= tone_pin;
    last_n_reg <= tone_n_pin;
  end
  assign tone_pin = tone_out_oe ? tone_out : ~last_reg;
  assign tone_n_pin = tone_out_n_oe ? tone_out_n : ~last_n_reg;
endmodule // pwb_pulse_src

// ===== tb.sv
// tb: self-checking bench for the pulse width timer and tone block
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e); \
    end \
  end
module tb
  import pwb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ***********************************************
  // signals and instances
  // ***********************************************
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  // response readies stay high: the bench never refuses an answer
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, sleep_mode = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h3;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_up;
  logic [1:0] s_axi_bresp, s_axi_rresp, timer_irq;
  logic ext_timer_input, ext_timer_input_16, src_pin;
  logic tone_out, tone_out_oe, tone_out_in, tone_out_n, tone_out_n_oe, tone_out_n_in;
  logic go = 1'b0, act = 1'b1, sel16 = 1'b0, cmp_on = 1'b0;
  logic [7:0] len = 8'h00;
  int n_mismatch = 0, check_count = 0, seed = 32'hd97bd374;
  logic [33:0] exp_q[$];
  int tol_q[$];
  always #25 sys_clk = ~sys_clk;
  pwb_timer dut_u
  (
    .sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_timer_input, .ext_timer_input_16, .tone_out, .tone_out_oe, .tone_out_in, .tone_out_n,
    .tone_out_n_oe, .tone_out_n_in, .timer_irq, .sleep_mode, .wake_up
  );
  pwb_pulse_src src_u
  (
    .sys_clk, .go, .len, .act_lvl(act), .ext_pin(src_pin), .tone_out, .tone_out_oe, .tone_out_n,
    .tone_out_n_oe, .tone_pin(tone_out_in), .tone_n_pin(tone_out_n_in)
  );
  // unused timer pin idles at its inactive level
  assign ext_timer_input = sel16 ? ~act : src_pin;
  assign ext_timer_input_16 = sel16 ? src_pin : ~act;
  // ***********************************************
  // bus tasks, result watcher, closing
  // ***********************************************
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    `CHK(s_axi_bresp, e)
  endtask
  // tol above zero: data only, within plus or minus tol
  task automatic rd(input logic [4:0] a, input logic [33:0] e, input int tol);
    exp_q.push_back(e);
    tol_q.push_back(tol);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
  endtask
  always @(posedge sys_clk)
  begin
    int g, e;
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
    begin
      g = int'(s_axi_rdata);
      e = int'(exp_q[0][31:0]);
      if (tol_q[0] == 0)
        `CHK({s_axi_rresp, s_axi_rdata}, exp_q[0])
      else
        `CHK(g >= e - tol_q[0] && g <= e + tol_q[0], 1'b1)
      void'(exp_q.pop_front());
      void'(tol_q.pop_front());
    end
  end
  always @(posedge sys_clk)
    if (cmp_on)
      `CHK(tone_out_in, ~tone_out_n_in)
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // span well above the roughly 10000 cycles the tests need
  initial
  begin
    #(50 * 40000);
    n_mismatch++;
    end_sim();
  end
  // ***********************************************
  // scenarios
  // ***********************************************
  initial
  begin
    int k, w, t, sel;
    logic [4:0] ca, na;
    logic [7:0] cv;
    logic tp;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(PWB_ADDR_CTRL8, {PWB_RESP_OKAY, 32'h0000_0000}, 0);
    rd(PWB_ADDR_PORTB_DIR, {PWB_RESP_OKAY, 32'h0000_0003}, 0);
    rd(5'h1C, {PWB_RESP_SLVERR, 32'h0000_0000}, 0);
    wr(5'h1C, 32'h0000_0000, PWB_RESP_SLVERR);
    // single-shot pulse width, both counters, both active levels
    for (k = 0; k < 4; k++)
    begin
      ca = k[1] ? PWB_ADDR_CTRL16 : PWB_ADDR_CTRL8;
      na = k[1] ? PWB_ADDR_CNT16 : PWB_ADDR_CNT8;
      cv = {2'b11, 2'b00, k[0], 3'b000};
      w = 30 + ($random(seed) & 63);
      sel16 <= k[1];
      act <= k[0];
      wr(na, 32'h0000_0000, PWB_RESP_OKAY);
      wr(ca, {24'h00_0000, cv}, PWB_RESP_OKAY);
      wr(ca, {24'h00_0000, cv | 8'h10}, PWB_RESP_OKAY);
      repeat (20) @(posedge sys_clk);
      rd(na, {PWB_RESP_OKAY, 32'h0000_0000}, 0);
      // second pulse must leave the residue alone
      for (t = 0; t < 2; t++)
      begin
        len <= 8'(w);
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (w + 12) @(posedge sys_clk);
        rd(ca, {PWB_RESP_OKAY, 24'h00_0000, cv}, 0);
        rd(na, {PWB_RESP_OKAY, 32'(w / (k[1] ? 4 : 2))}, 2);
      end
    end
    // event mode counts rising edges on the timer8 pin
    sel16 <= 1'b0;
    wr(PWB_ADDR_CNT8, 32'h0000_0000, PWB_RESP_OKAY);
    wr(PWB_ADDR_CTRL8, 32'h0000_0040, PWB_RESP_OKAY);
    wr(PWB_ADDR_CTRL8, 32'h0000_0050, PWB_RESP_OKAY);
    repeat (3)
    begin
      len <= 8'h04;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (8) @(posedge sys_clk);
    end
    rd(PWB_ADDR_CNT8, {PWB_RESP_OKAY, 32'h0000_0003}, 0);
    wr(PWB_ADDR_CTRL8, 32'h0000_0000, PWB_RESP_OKAY);
    // timer mode overflow at every prescale ratio
    wr(PWB_ADDR_INTC, 32'h0000_0001, PWB_RESP_OKAY);
    for (sel = 0; sel < 8; sel++)
    begin
      wr(PWB_ADDR_CNT8, 32'h0000_00F0, PWB_RESP_OKAY);
      wr(PWB_ADDR_CTRL8, 32'h0000_0080 | sel, PWB_RESP_OKAY);
      wr(PWB_ADDR_CTRL8, 32'h0000_0090 | sel, PWB_RESP_OKAY);
      t = 0;
      while (timer_irq[0] !== 1'b1 && t < 5000)
      begin
        @(posedge sys_clk);
        t++;
      end
      `CHK(t >= 15 * (2 << sel) && t <= 17 * (2 << sel) + 4, 1'b1)
      rd(PWB_ADDR_CTRL8, {PWB_RESP_OKAY, 32'h0000_0090 | sel}, 0);
      rd(PWB_ADDR_INTC, {PWB_RESP_OKAY, 32'h0000_0005}, 0);
      rd(PWB_ADDR_CNT8, {PWB_RESP_OKAY, 32'h0000_00F8}, 8);
      wr(PWB_ADDR_CTRL8, 32'h0000_0000, PWB_RESP_OKAY);
      wr(PWB_ADDR_INTC, 32'h0000_0001, PWB_RESP_OKAY);
    end
    // masked irq, asleep, tone pair gated on
    wr(PWB_ADDR_INTC, 32'h0000_0000, PWB_RESP_OKAY);
    wr(PWB_ADDR_PORTB_DIR, 32'h0000_0000, PWB_RESP_OKAY);
    wr(PWB_ADDR_PORTB, 32'h0000_0001 | ($random(seed) & 2), PWB_RESP_OKAY);
    sleep_mode <= 1'b1;
    wr(PWB_ADDR_CTRL8, 32'h0000_0080, PWB_RESP_OKAY);
    wr(PWB_ADDR_CTRL8, 32'h0000_0090, PWB_RESP_OKAY);
    cmp_on <= 1'b1;
    t = 0;
    w = 0;
    k = 0;
    tp = tone_out_in;
    repeat (200)
    begin
      @(posedge sys_clk);
      t += int'(wake_up);
      k |= int'(timer_irq[0]);
      w += int'(tone_out_in !== tp);
      tp = tone_out_in;
    end
    `CHK(t, 1)
    `CHK(k, 0)
    `CHK(w >= 5 && w <= 7, 1'b1)
    `CHK({tone_out_oe, tone_out_n_oe}, 2'b11)
    rd(PWB_ADDR_INTC, {PWB_RESP_OKAY, 32'h0000_0004}, 0);
    // gate off leaves both low whatever the second bit says
    cmp_on <= 1'b0;
    wr(PWB_ADDR_PORTB, 32'h0000_0002, PWB_RESP_OKAY);
    repeat (40) @(posedge sys_clk);
    `CHK({tone_out_in, tone_out_n_in}, 2'b00)
    wr(PWB_ADDR_PORTB_DIR, 32'h0000_0003, PWB_RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    `CHK({tone_out_oe, tone_out_n_oe}, 2'b00)
    end_sim();
  end
endmodule // tb
